/* hdl/ptd_pkg.sv */
package ptd_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD   = 8'h00;
    localparam logic [7:0] ADDR_OPND  = 8'h04;
    localparam logic [7:0] ADDR_FPSR  = 8'h08;
    localparam logic [7:0] ADDR_CORE  = 8'h0c;
    localparam logic [7:0] ADDR_DEC   = 8'h10;
    localparam logic [7:0] ADDR_HOPND = 8'h14;

    localparam logic [31:0] FPSR_RST  = 32'h0000_0000;
    localparam logic [31:0] WORD_RST  = 32'h0000_0000;

    // ------------------------------------------------------------
    // Instruction word fields
    // ------------------------------------------------------------
    localparam logic [3:0] OP_LINE    = 4'hf;
    localparam logic [2:0] OP_GENERAL = 3'b000;
    localparam logic [5:0] OP_TRAP    = 6'b001111;
    localparam logic [6:0] OPC_POW10  = 7'b0010010;

    localparam logic [2:0] FMT_L = 3'b000;
    localparam logic [2:0] FMT_S = 3'b001;
    localparam logic [2:0] FMT_X = 3'b010;
    localparam logic [2:0] FMT_P = 3'b011;
    localparam logic [2:0] FMT_W = 3'b100;
    localparam logic [2:0] FMT_D = 3'b101;
    localparam logic [2:0] FMT_B = 3'b110;

    localparam logic [2:0] EA_DREG = 3'b000;
    localparam logic [2:0] EA_AREG = 3'b001;
    localparam logic [2:0] EA_IND  = 3'b010;
    localparam logic [2:0] EA_POST = 3'b011;
    localparam logic [2:0] EA_PRE  = 3'b100;
    localparam logic [2:0] EA_DISP = 3'b101;
    localparam logic [2:0] EA_IDX  = 3'b110;
    localparam logic [2:0] EA_EXT  = 3'b111;
    localparam logic [2:0] EX_ABSW = 3'b000;
    localparam logic [2:0] EX_ABSL = 3'b001;
    localparam logic [2:0] EX_PCD  = 3'b010;
    localparam logic [2:0] EX_PCX  = 3'b011;
    localparam logic [2:0] EX_IMM  = 3'b100;

    localparam logic [2:0] TM_WORD = 3'b010;
    localparam logic [2:0] TM_LONG = 3'b011;
    localparam logic [2:0] TM_NONE = 3'b100;

    // ------------------------------------------------------------
    // Status word layout
    // ------------------------------------------------------------
    localparam int CC_LSB  = 24;
    localparam int QUO_LSB = 16;
    localparam int EXC_LSB = 8;
    localparam int ACC_LSB = 0;
    localparam int CC_N    = 3;
    localparam int CC_Z    = 2;
    localparam int CC_NAN  = 0;
    localparam int EXC_UCMP  = 7;
    localparam int EXC_SGNL  = 6;
    localparam int EXC_BADOP = 5;
    localparam int EXC_OVER  = 4;
    localparam int EXC_UNDR  = 3;
    localparam int EXC_DIV0  = 2;
    localparam int EXC_INXR  = 1;
    localparam int EXC_INXI  = 0;
    localparam int ACC_INV   = 7;
    localparam int ACC_OVER  = 6;
    localparam int ACC_UNDR  = 5;
    localparam int ACC_DIV0  = 4;
    localparam int ACC_INX   = 3;
    localparam int CF_SGNL = 0;
    localparam int CF_OVER = 1;
    localparam int CF_UNDR = 2;
    localparam int CF_INXR = 3;
    localparam int CF_INXI = 4;

    typedef enum logic [1:0] {
        PTD_CLS_NONE  = 2'b00,
        PTD_CLS_POW10 = 2'b01,
        PTD_CLS_TRAP  = 2'b10,
        PTD_CLS_ILL   = 2'b11
    } ptd_cls_t;

endpackage

/* hdl/ptd_cond_eval.sv */
`timescale 1ns/1ns
`default_nettype none
module ptd_cond_eval (
    input  wire logic [5:0] pred,       // Predicate field
    input  wire logic       cc_n,       // Negative code
    input  wire logic       cc_z,       // Zero code
    input  wire logic       cc_nan,     // Unordered code
    output logic            pred_ok,    // Top predicate bit clear
    output logic            hit,        // Condition true
    output logic            non_aware   // Test ignores unordered
);
    logic [15:0] tbl;

    // Low four bits pick the relation; bit four marks the non-aware set
    assign tbl = {1'b1, ~cc_z, cc_nan | cc_z | cc_n,
                  cc_nan | (cc_n & ~cc_z), cc_nan | cc_z | ~cc_n,
                  cc_nan | ~(cc_n | cc_z), cc_nan | cc_z, cc_nan,
                  ~cc_nan, ~(cc_nan | cc_z), cc_z | (cc_n & ~cc_nan),
                  cc_n & ~(cc_nan | cc_z), cc_z | ~(cc_nan | cc_n),
                  ~(cc_nan | cc_z | cc_n), cc_z, 1'b0};
    assign hit       = tbl[pred[3:0]];
    assign non_aware = pred[4];
    assign pred_ok   = ~pred[5];
endmodule // ptd_cond_eval
`default_nettype wire

/* hdl/ptd_decode_top.sv */
// What this block does
// - Power of ten result goes to destination
// - Inexact input cleared unless packed source
// - Accrued byte gathers new exception bits
// - Act only on own coprocessor identifier
// - Address mode and register codes decoded
// - Data register only for small formats
// - Mode bit picks register or memory source
// - Register mode names source fp register
// - Memory mode source field gives format
// - Equal fields read, write same register
// - True trap gives vector, next address
// - False trap raises no request, execution continues
// - Predicate picks one of 32 tests
// - Trap mode gives operand form
// - Unordered flag set on non-aware unordered test
// - Accrued invalid set from unordered flag
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ptd_decode_top #(
    parameter logic [2:0] OWN_CID     = 3'h1,  // Assigned identifier
    parameter logic [7:0] TRAP_VECTOR = 8'h07  // Trap vector number
) (
    input  wire logic        hclk,        // Bus clock
    input  wire logic        hresetn,     // Async reset, low
    input  wire logic        hsel,        // Slave select
    input  wire logic [31:0] haddr,       // Byte address
    input  wire logic [1:0]  htrans,      // Transfer type
    input  wire logic        hwrite,      // Write flag
    input  wire logic [2:0]  hsize,       // Transfer size
    input  wire logic [31:0] hwdata,      // Write data
    input  wire logic        hready,      // Bus ready
    output logic      [31:0] hrdata,      // Read data
    output logic             hreadyout,   // Slave ready
    output logic             hresp,       // Response
    output logic             trap_req,    // Trap request pulse
    output logic      [7:0]  trap_vector, // Vector of trap
    output logic             fp_wr_req,   // Result write pulse
    output logic      [2:0]  fp_wr_reg,   // Result register
    output logic      [2:0]  fp_rd_reg,   // Source register
    output logic             cvt_ext      // Source needs conversion
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic        wr_pend_q;
    logic [7:0]  waddr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;
    wire         ap_take = hsel & htrans[1] & hready;
    wire         wr_cmd  = wr_pend_q & (waddr_q == ptd_pkg::ADDR_CMD);
    wire         wr_opnd = wr_pend_q & (waddr_q == ptd_pkg::ADDR_OPND);
    wire         wr_fpsr = wr_pend_q & (waddr_q == ptd_pkg::ADDR_FPSR);
    wire         wr_core = wr_pend_q & (waddr_q == ptd_pkg::ADDR_CORE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            waddr_q   <= 8'h00;
            hrdata_q  <= ptd_pkg::WORD_RST;
        end else begin
            wr_pend_q <= ap_take & hwrite;
            waddr_q   <= haddr[7:0];
            if (ap_take && !hwrite) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
    assign hrdata = hrdata_q;

    // ------------------------------------------------------------
    // Software-held state
    // ------------------------------------------------------------
    logic [31:0] opnd_q;
    logic [31:0] fpsr_q;
    logic [31:0] fpsr_d;
    logic [4:0]  core_q;
    logic [31:0] dec_q;
    logic [31:0] dec_d;
    logic [31:0] hopnd_q;
    logic [31:0] hopnd_d;

    // ------------------------------------------------------------
    // Field extraction from the command written now
    // ------------------------------------------------------------
    wire [15:0] opw = hwdata[31:16];
    wire [15:0] ext = hwdata[15:0];
    wire        rm  = ext[14];
    wire [2:0]  src = ext[12:10];
    wire [2:0]  dst = ext[9:7];
    wire [2:0]  eam = opw[5:3];
    wire [2:0]  ear = opw[2:0];
    wire [2:0]  tmode = opw[2:0];

    wire cid_ok = (opw[15:12] == ptd_pkg::OP_LINE) && (opw[11:9] == OWN_CID);

    wire gen_ok = (opw[8:6] == ptd_pkg::OP_GENERAL) && !ext[15] && !ext[13]
                  && (ext[6:0] == ptd_pkg::OPC_POW10);

    wire fmt_ok = (src != 3'b111);
    wire small_fmt = (src == ptd_pkg::FMT_L) || (src == ptd_pkg::FMT_S)
                     || (src == ptd_pkg::FMT_W) || (src == ptd_pkg::FMT_B);
    wire ext_ok = (ear == ptd_pkg::EX_ABSW) || (ear == ptd_pkg::EX_ABSL)
                  || (ear == ptd_pkg::EX_PCD) || (ear == ptd_pkg::EX_PCX)
                  || (ear == ptd_pkg::EX_IMM);
    wire ea_ok = (eam == ptd_pkg::EA_AREG) ? 1'b0 :
                 (eam == ptd_pkg::EA_DREG) ? small_fmt :
                 (eam == ptd_pkg::EA_EXT)  ? ext_ok : 1'b1;
    // Register mode ignores the address field; a non-zero one is tolerated
    wire pow_ok = gen_ok & (!rm | (fmt_ok & ea_ok));

    // Address class: modes 0..6 as is, extended modes as 8 + register
    wire [3:0] ea_cls = (eam == ptd_pkg::EA_EXT) ? {1'b1, ear} : {1'b0, eam};

    // ------------------------------------------------------------
    // Conditional trap
    // ------------------------------------------------------------
    logic pred_ok;
    logic cond_hit;
    logic non_aware;

    ptd_cond_eval u_cond (
        .pred      (ext[5:0]),
        .cc_n      (fpsr_q[ptd_pkg::CC_LSB + ptd_pkg::CC_N]),
        .cc_z      (fpsr_q[ptd_pkg::CC_LSB + ptd_pkg::CC_Z]),
        .cc_nan    (fpsr_q[ptd_pkg::CC_LSB + ptd_pkg::CC_NAN]),
        .pred_ok   (pred_ok),
        .hit       (cond_hit),
        .non_aware (non_aware)
    );

    wire tmode_ok = (tmode == ptd_pkg::TM_WORD) || (tmode == ptd_pkg::TM_LONG)
                    || (tmode == ptd_pkg::TM_NONE);
    wire trap_ok = (opw[8:3] == ptd_pkg::OP_TRAP) && tmode_ok
                   && (ext[15:6] == 10'h000) && pred_ok;
    wire [1:0] opnd_words = (tmode == ptd_pkg::TM_WORD) ? 2'd1 :
                            (tmode == ptd_pkg::TM_LONG) ? 2'd2 : 2'd0;
    // Address after the trap in words: opword, predicate, operand words
    wire [2:0] next_pc_w = 3'd2 + {1'b0, opnd_words};

    wire ex_pow  = wr_cmd & cid_ok & pow_ok;
    wire ex_trap = wr_cmd & cid_ok & trap_ok;
    wire ex_ill  = wr_cmd & cid_ok & !pow_ok & !trap_ok;
    wire taken   = ex_trap & cond_hit;

    ptd_pkg::ptd_cls_t cls;
    assign cls = ex_pow  ? ptd_pkg::PTD_CLS_POW10 :
                 ex_trap ? ptd_pkg::PTD_CLS_TRAP  :
                 ex_ill  ? ptd_pkg::PTD_CLS_ILL   : ptd_pkg::PTD_CLS_NONE;

    // ------------------------------------------------------------
    // Exception and accrued byte update
    // ------------------------------------------------------------
    wire [7:0] exc_old = fpsr_q[ptd_pkg::EXC_LSB +: 8];
    wire [7:0] acc_old = fpsr_q[ptd_pkg::ACC_LSB +: 8];
    wire       bcd_src = rm && (src == ptd_pkg::FMT_P);
    logic [7:0] exc_pow;
    logic [7:0] exc_trap;
    logic [7:0] acc_pow;
    logic [7:0] acc_trap;

    always_comb begin
        exc_pow = 8'h00;
        exc_pow[ptd_pkg::EXC_SGNL] = core_q[ptd_pkg::CF_SGNL];
        exc_pow[ptd_pkg::EXC_OVER] = core_q[ptd_pkg::CF_OVER];
        exc_pow[ptd_pkg::EXC_UNDR] = core_q[ptd_pkg::CF_UNDR];
        exc_pow[ptd_pkg::EXC_INXR] = core_q[ptd_pkg::CF_INXR];
        exc_pow[ptd_pkg::EXC_INXI] = bcd_src & core_q[ptd_pkg::CF_INXI];
        acc_pow = acc_old;
        acc_pow[ptd_pkg::ACC_INV]  = acc_old[ptd_pkg::ACC_INV]
            | exc_pow[ptd_pkg::EXC_UCMP] | exc_pow[ptd_pkg::EXC_SGNL]
            | exc_pow[ptd_pkg::EXC_BADOP];
        acc_pow[ptd_pkg::ACC_OVER] = acc_old[ptd_pkg::ACC_OVER]
            | exc_pow[ptd_pkg::EXC_OVER];
        // Underflow accrues only when the result is also inexact
        acc_pow[ptd_pkg::ACC_UNDR] = acc_old[ptd_pkg::ACC_UNDR]
            | (exc_pow[ptd_pkg::EXC_UNDR] & exc_pow[ptd_pkg::EXC_INXR]);
        acc_pow[ptd_pkg::ACC_DIV0] = acc_old[ptd_pkg::ACC_DIV0]
            | exc_pow[ptd_pkg::EXC_DIV0];
        acc_pow[ptd_pkg::ACC_INX]  = acc_old[ptd_pkg::ACC_INX]
            | exc_pow[ptd_pkg::EXC_INXR] | exc_pow[ptd_pkg::EXC_INXI]
            | exc_pow[ptd_pkg::EXC_OVER];
    end

    wire ucmp_set = fpsr_q[ptd_pkg::CC_LSB + ptd_pkg::CC_NAN] & non_aware;

    always_comb begin
        exc_trap = exc_old;
        exc_trap[ptd_pkg::EXC_UCMP] = exc_old[ptd_pkg::EXC_UCMP] | ucmp_set;
        acc_trap = acc_old;
        acc_trap[ptd_pkg::ACC_INV] = acc_old[ptd_pkg::ACC_INV]
            | exc_trap[ptd_pkg::EXC_UCMP];
    end

    // One bus write per cycle, so software and hardware never collide here
    always_comb begin
        fpsr_d = fpsr_q;
        if (wr_fpsr) begin
            fpsr_d = hwdata;
        end else if (ex_pow) begin
            fpsr_d[ptd_pkg::EXC_LSB +: 8] = exc_pow;
            fpsr_d[ptd_pkg::ACC_LSB +: 8] = acc_pow;
        end else if (ex_trap) begin
            fpsr_d[ptd_pkg::EXC_LSB +: 8] = exc_trap;
            fpsr_d[ptd_pkg::ACC_LSB +: 8] = acc_trap;
        end
    end

    // ------------------------------------------------------------
    // Decode status and handler operand
    // ------------------------------------------------------------
    wire same_reg = !rm && (src == dst);
    assign dec_d = wr_cmd ?
        {3'h0, TRAP_VECTOR, next_pc_w, 1'b0, ea_cls, dst, src, same_reg, rm,
         taken, cls, !cid_ok, 1'b1} : dec_q;

    always_comb begin
        hopnd_d = hopnd_q;
        if (ex_trap) begin
            case (tmode)
                ptd_pkg::TM_WORD: hopnd_d = {16'h0000, opnd_q[15:0]};
                ptd_pkg::TM_LONG: hopnd_d = opnd_q;
                default:          hopnd_d = ptd_pkg::WORD_RST;
            endcase
        end
    end

    always_comb begin
        case (haddr[7:0])
            ptd_pkg::ADDR_OPND:  rd_mux = wr_opnd ? hwdata : opnd_q;
            ptd_pkg::ADDR_FPSR:  rd_mux = fpsr_d;
            ptd_pkg::ADDR_CORE:  rd_mux = {27'h0, wr_core ? hwdata[4:0] : core_q};
            ptd_pkg::ADDR_DEC:   rd_mux = dec_d;
            ptd_pkg::ADDR_HOPND: rd_mux = hopnd_d;
            default:             rd_mux = ptd_pkg::WORD_RST;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opnd_q  <= ptd_pkg::WORD_RST;
            fpsr_q  <= ptd_pkg::FPSR_RST;
            core_q  <= 5'h00;
            dec_q   <= ptd_pkg::WORD_RST;
            hopnd_q <= ptd_pkg::WORD_RST;
        end else begin
            if (wr_opnd) begin
                opnd_q <= hwdata;
            end
            if (wr_core) begin
                core_q <= hwdata[4:0];
            end
            fpsr_q  <= fpsr_d;
            dec_q   <= dec_d;
            hopnd_q <= hopnd_d;
        end
    end

    // ------------------------------------------------------------
    // Host and register file strobes
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trap_req    <= 1'b0;
            trap_vector <= 8'h00;
            fp_wr_req   <= 1'b0;
            fp_wr_reg   <= 3'h0;
            fp_rd_reg   <= 3'h0;
            cvt_ext     <= 1'b0;
        end else begin
            trap_req  <= taken;
            fp_wr_req <= ex_pow;
            if (taken) begin
                trap_vector <= TRAP_VECTOR;
            end
            if (ex_pow) begin
                fp_wr_reg <= dst;
                fp_rd_reg <= rm ? dst : src;
                cvt_ext   <= rm && (src != ptd_pkg::FMT_X);
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_CID: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_cmd && !cid_ok) |=> (!trap_req && !fp_wr_req && $stable(fpsr_q)))
        else $error("foreign identifier acted upon");

    AST_TRAP: assert property (@(posedge hclk) disable iff (!hresetn)
        taken |=> (trap_req && trap_vector == TRAP_VECTOR && dec_q[4]) ##1 !trap_req)
        else $error("true trap not requested for one cycle");

    AST_FALSE: assert property (@(posedge hclk) disable iff (!hresetn)
        (ex_trap && !cond_hit) |=> !trap_req && !dec_q[4])
        else $error("false trap raised a request");

    AST_INXI: assert property (@(posedge hclk) disable iff (!hresetn)
        (ex_pow && !bcd_src) |=> !fpsr_q[ptd_pkg::EXC_LSB + ptd_pkg::EXC_INXI])
        else $error("inexact input not cleared");

    AST_ACCRUE: assert property (@(posedge hclk) disable iff (!hresetn)
        ex_pow |=> ((fpsr_q[7:0] & $past(acc_old)) == $past(acc_old))
        && (fpsr_q[ptd_pkg::ACC_OVER] || !fpsr_q[ptd_pkg::EXC_LSB + ptd_pkg::EXC_OVER]))
        else $error("accrued byte lost or missed a bit");

    AST_AREG: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_cmd && cid_ok && gen_ok && rm && eam == ptd_pkg::EA_AREG)
        |=> !fp_wr_req && dec_q[3:2] == ptd_pkg::PTD_CLS_ILL)
        else $error("address register mode accepted");

    AST_UCMP: assert property (@(posedge hclk) disable iff (!hresetn)
        (ex_trap && ucmp_set) |=> fpsr_q[ptd_pkg::EXC_LSB + ptd_pkg::EXC_UCMP]
        && fpsr_q[ptd_pkg::EXC_LSB +: 7] == $past(exc_old[6:0]))
        else $error("unordered flag wrong after trap");

    AST_INV: assert property (@(posedge hclk) disable iff (!hresetn)
        ex_trap |=> (fpsr_q[ptd_pkg::ACC_INV] == ($past(acc_old[ptd_pkg::ACC_INV])
        | fpsr_q[ptd_pkg::EXC_LSB + ptd_pkg::EXC_UCMP])) && fpsr_q[6:0] == $past(acc_old[6:0]))
        else $error("accrued invalid not tracking flag");

    AST_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
        ex_trap |=> fpsr_q[31:16] == $past(fpsr_q[31:16]))
        else $error("trap changed codes or quotient");

    AST_SAME: assert property (@(posedge hclk) disable iff (!hresetn)
        (ex_pow && same_reg) |=> fp_wr_req && fp_rd_reg == fp_wr_reg)
        else $error("same register not reused");

    COV_POW: cover property (@(posedge hclk) disable iff (!hresetn) ex_pow && bcd_src);
    COV_TRAP: cover property (@(posedge hclk) disable iff (!hresetn) taken);
    COV_UCMP: cover property (@(posedge hclk) disable iff (!hresetn) ex_trap && ucmp_set);
endmodule // ptd_decode_top
`default_nettype wire

/* tb/ptd_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Host that issues coprocessor instructions
// ----------------------------------------
module ptd_host_model (
    input  wire logic        hclk,        // Clock
    input  wire logic        hready,      // Bus ready
    input  wire logic [31:0] hrdata,      // Read data
    input  wire logic        trap_req,    // Trap request
    input  wire logic [7:0]  trap_vector, // Trap vector
    output logic             hsel,        // Select
    output logic      [31:0] haddr,       // Address
    output logic      [1:0]  htrans,      // Transfer type
    output logic             hwrite,      // Write flag
    output logic      [31:0] hwdata       // Write data
);
    int         n_exc    = 0;
    logic [7:0] vec_seen = 8'h00;
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
    end
    // Exception entry on a true trap
    always @(posedge hclk) begin
        if (trap_req === 1'b1) begin
            n_exc    <= n_exc + 1;
            vec_seen <= trap_vector;
        end
    end
    // Unused address field stays zero
    function automatic logic [31:0] pw_cmd(logic [2:0] cid, logic rm, logic [5:0] ea,
                                           logic [2:0] src, logic [2:0] dst);
        return {4'hf, cid, 3'h0, rm ? ea : 6'h00, 1'b0, rm, 1'b0, src, dst,
                ptd_pkg::OPC_POW10};
    endfunction
    function automatic logic [31:0] tr_cmd(logic [2:0] cid, logic [2:0] mo, logic [5:0] p);
        return {4'hf, cid, ptd_pkg::OP_TRAP, mo, 10'h000, p};
    endfunction
    // Address phase held until ready, then data phase until ready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
endmodule // ptd_host_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam logic [7:0] VEC = 8'h07;
    typedef struct packed {
        logic [2:0] cid; logic rm; logic [5:0] ea;
        logic [2:0] src; logic [2:0] dst; logic [4:0] core; logic [1:0] cls;
    } ptd_row_t;
    logic hclk = 1'b0, hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, trap_req, fp_wr_req, cvt_ext;
    logic [31:0] haddr, hwdata, hrdata, d, f0;
    logic [1:0]  htrans;
    logic [7:0]  trap_vector;
    logic [2:0]  fp_wr_reg, fp_rd_reg, mo;
    int failures = 0, checks_done = 0, cyc = 0, nhit = 0;
    logic hit, b;
    ptd_row_t r;
    ptd_row_t rows [12] = '{
        '{3'h1,1'b0,6'h00,3'h3,3'h5,5'h1f,2'h1}, '{3'h1,1'b0,6'h00,3'h4,3'h4,5'h00,2'h1},
        '{3'h1,1'b1,6'h10,3'h3,3'h2,5'h10,2'h1}, '{3'h1,1'b1,6'h03,3'h2,3'h1,5'h1f,2'h3},
        '{3'h1,1'b1,6'h03,3'h4,3'h7,5'h0a,2'h1}, '{3'h1,1'b1,6'h09,3'h0,3'h1,5'h00,2'h3},
        '{3'h1,1'b1,6'h3c,3'h5,3'h0,5'h04,2'h1}, '{3'h1,1'b1,6'h3d,3'h5,3'h0,5'h00,2'h3},
        '{3'h1,1'b1,6'h10,3'h7,3'h0,5'h00,2'h3}, '{3'h2,1'b1,6'h10,3'h3,3'h2,5'h1f,2'h0},
        '{3'h1,1'b1,6'h00,3'h6,3'h3,5'h1f,2'h1}, '{3'h1,1'b1,6'h10,3'h2,3'h6,5'h1c,2'h1}};
    // Condition codes and the 16 test outcomes under each
    logic [3:0]  cc_tab [4] = '{4'h1, 4'h4, 4'h8, 4'h0};
    logic [15:0] mask   [4] = '{16'hff00, 16'haaaa, 16'hf0f0, 16'hcccc};
    always #25 hclk = ~hclk;
    ptd_host_model u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .trap_req(trap_req), .trap_vector(trap_vector), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
    ptd_decode_top #(.OWN_CID(3'h1), .TRAP_VECTOR(VEC)) u_dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .trap_req(trap_req),
        .trap_vector(trap_vector), .fp_wr_req(fp_wr_req), .fp_wr_reg(fp_wr_reg),
        .fp_rd_reg(fp_rd_reg), .cvt_ext(cvt_ext));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic results;
        if (failures == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        u_host.xfer(1'b1, a, v, x);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        u_host.xfer(1'b0, a, 32'h0, x);
        chk(nm, e, x);
    endtask
    // Pulses stand one cycle after the command's data phase
    task automatic exec(input logic [31:0] c, input logic t, input logic w);
        wr(ptd_pkg::ADDR_CMD, c);
        @(posedge hclk);
        chk("pulses", {30'h0, t, w}, {30'h0, trap_req, fp_wr_req});
        @(posedge hclk);
        chk("pulses_end", 32'h0, {29'h0, hresp, trap_req, fp_wr_req});
    endtask
    function automatic logic [31:0] pw(logic [31:0] f, logic [4:0] c, logic pk);
        logic [7:0] e;
        e = {1'b0, c[0], 1'b0, c[1], c[2], 1'b0, c[3], c[4] & pk};
        return {f[31:16], e, f[7:0] | {c[0], c[1], c[2] & c[3], 1'b0, e[0] | c[3] | c[1], 3'h0}};
    endfunction
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge hclk);
        chk("ready_in_reset", 32'h0, 32'(hreadyout));
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc("fpsr_rst", ptd_pkg::ADDR_FPSR, ptd_pkg::FPSR_RST);
        rdc("dec_rst", ptd_pkg::ADDR_DEC, ptd_pkg::WORD_RST);
        foreach (rows[i]) begin
            r = rows[i];
            f0 = 32'h0b5a_ff01;
            wr(ptd_pkg::ADDR_FPSR, f0);
            wr(ptd_pkg::ADDR_CORE, 32'(r.core));
            exec(u_host.pw_cmd(r.cid, r.rm, r.ea, r.src, r.dst), 1'b0, r.cls == 2'h1);
            if (r.cls == 2'h1) begin
                chk("fp_wr_reg", 32'(r.dst), 32'(fp_wr_reg));
                chk("fp_rd_reg", 32'(r.rm ? r.dst : r.src), 32'(fp_rd_reg));
                chk("cvt_ext", 32'(r.rm && r.src != ptd_pkg::FMT_X), 32'(cvt_ext));
                f0 = pw(f0, r.core, r.rm && r.src == ptd_pkg::FMT_P);
            end
            rdc("fpsr_pow", ptd_pkg::ADDR_FPSR, f0);
            u_host.xfer(1'b0, ptd_pkg::ADDR_DEC, 32'h0, d);
            chk("dec", 32'({r.cls, r.cid != 3'h1, 1'b1}), 32'(d[3:0]));
            chk("dec_mode", 32'({r.rm ? 1'b0 : r.src == r.dst, r.rm}), 32'(d[6:5]));
        end
        exec(u_host.pw_cmd(3'h1, 1'b0, 6'h00, 3'h3, 3'h5) | 32'h8000, 1'b0, 1'b0);
        for (int k = 0; k < 12; k++) begin
            exec(u_host.pw_cmd(3'h1, 1'b1, 6'(k < 7 ? k * 8 + 3 : k + 49), 3'h0, 3'h0),
                 1'b0, k != 1);
            u_host.xfer(1'b0, ptd_pkg::ADDR_DEC, 32'h0, d);
            if (k != 1) chk("ea_class", 32'(k < 7 ? k : k + 1), 32'(d[16:13]));
        end
        foreach (cc_tab[j]) for (int p = 0; p < 32; p++) begin
            mo = 3'(2 + p % 3);
            wr(ptd_pkg::ADDR_OPND, 32'hbeef_1234);
            f0 = {4'h0, cc_tab[j], 24'h5a_7e05};
            wr(ptd_pkg::ADDR_FPSR, f0);
            hit = mask[j][p % 16];
            nhit += hit;
            exec(u_host.tr_cmd(3'h1, mo, 6'(p)), hit, 1'b0);
            b = cc_tab[j][0] & p[4];
            f0 = f0 | {16'h0, b, 7'h0, b, 7'h0};
            rdc("fpsr_trap", ptd_pkg::ADDR_FPSR, f0);
            u_host.xfer(1'b0, ptd_pkg::ADDR_DEC, 32'h0, d);
            chk("dec_trap", 32'({VEC, mo == 3'h4 ? 3'h2 : mo + 3'h1, hit, 2'h2}),
                32'({d[28:18], d[4:2]}));
            rdc("opnd", ptd_pkg::ADDR_HOPND, mo == ptd_pkg::TM_WORD ? 32'h1234 :
                mo == ptd_pkg::TM_LONG ? 32'hbeef_1234 : 32'h0);
        end
        chk("exc_count", 32'(nhit), 32'(u_host.n_exc));
        chk("vector", 32'(VEC), 32'(u_host.vec_seen));
        exec(u_host.tr_cmd(3'h1, ptd_pkg::TM_NONE, 6'h20), 1'b0, 1'b0);
        u_host.xfer(1'b0, ptd_pkg::ADDR_DEC, 32'h0, d);
        chk("dec_ill", 32'h3, 32'(d[3:2]));
        wr(8'h40, 32'hffff_ffff);
        rdc("unmapped", 8'h40, 32'h0);
        rdc("cmd_read", ptd_pkg::ADDR_CMD, 32'h0);
        // Second reset in mid-run must clear the status word
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("ready_in_reset", 32'h0, 32'(hreadyout));
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc("fpsr_rst", ptd_pkg::ADDR_FPSR, ptd_pkg::FPSR_RST);
        results();
    end
endmodule // tb_top
`default_nettype wire
